// File: hdl/adcc_core.sv
// control core of a successive-approximation converter: apb registers,
// sequencing, accumulation, window compare, interrupt and result event.
// assumes the analog front end runs on clk and answers each sample_req with
// a one-cycle sample_done carrying sample_data.
`timescale 1ns/1ps
`include "adcc_regs.svh"

module adcc_core
  import adcc_pkg::*;
#(
  parameter int SAMPLE_W = 10,
  parameter int RESULT_W = 16
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state
  input wire logic standby_sleep,
  input wire logic debug_halt,
  input wire logic start_event,
  // analog front end
  output logic sample_req,
  input wire logic sample_done,
  input wire logic [SAMPLE_W-1:0] sample_data,
  output logic converter_clock_tick,
  output logic [4:0] input_channel,
  output logic [1:0] reference_select,
  output logic sample_cap,
  // events and interrupt
  output logic result_ready_event,
  output logic window_match_event,
  output logic irq
);

  // parameters the datapath cannot serve, refused at elaboration
  if (SAMPLE_W != 10 || RESULT_W != 16) begin : g_bad_width
    $error("adcc_core supports only 10-bit samples and a 16-bit result");
  end

  // number of samples per conversion minus one; reserved code 7 acts as 64
  function automatic logic [5:0] last_sample_index(input logic [2:0] code);
    case (code)
      3'h0: last_sample_index = 6'h00;
      3'h1: last_sample_index = 6'h01;
      3'h2: last_sample_index = 6'h03;
      3'h3: last_sample_index = 6'h07;
      3'h4: last_sample_index = 6'h0F;
      3'h5: last_sample_index = 6'h1F;
      default: last_sample_index = 6'h3F;
    endcase
  endfunction : last_sample_index

  // reset synchroniser, asynchronous assert
  logic rst_meta_n, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // registers
  logic [7:0] control_main, control_reference_prescale, control_delays, byte_staging;
  logic [2:0] accumulation_count, window_mode;
  logic [4:0] sample_length, input_select;
  logic [1:0] interrupt_enable, interrupt_flags;
  logic start_event_input, run_in_debug, duty_cycle_select;
  logic [15:0] conversion_result, window_low_threshold, window_high_threshold;

  // sequencer state
  adcc_state_type state, next_state;
  logic start_conversion, event_meta, event_sync, event_last;
  logic [15:0] accumulator;
  logic [5:0] sample_index;
  logic [7:0] prescale_count;

  // decoded control
  logic enable, free_running, resolution_select, run_in_standby;
  logic run_ok, last_sample, window_hit;
  logic [15:0] sample_value, next_sum;

  // apb decode
  logic setup_phase, wr_access, mapped, sw_start, hw_start;
  logic [5:0] idx;
  logic [31:0] read_value;
  logic [1:0] flag_clear, flag_set;

  assign enable = control_main[`ADCC_BIT_ENABLE];
  assign free_running = control_main[`ADCC_BIT_FREE_RUNNING];
  assign resolution_select = control_main[`ADCC_BIT_RESOLUTION_SELECT];
  assign run_in_standby = control_main[`ADCC_BIT_RUN_IN_STANDBY];

  // halted, not abandoned, while asleep or under debug without permission
  assign run_ok = enable & ~(standby_sleep & ~run_in_standby)
    & ~(debug_halt & ~run_in_debug);

  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite & ce & (paddr[1:0] == 2'h0); // refused if misaligned
  assign idx = paddr[7:2];
  assign pready = 1'b1;

  // sample width handling
  always_comb begin
    if (resolution_select) begin
      sample_value = {8'h00, sample_data[9:2]};
    end else begin
      sample_value = {6'h00, sample_data};
    end
  end

  // running sum wraps at 16 bits, enough for 64 full-scale samples
  assign next_sum = accumulator + sample_value;
  assign last_sample = (sample_index == last_sample_index(accumulation_count));

  // window compare on the finished result
  always_comb begin
    case (window_mode)
      `ADCC_WIN_BELOW: window_hit = next_sum < window_low_threshold;
      `ADCC_WIN_ABOVE: window_hit = next_sum > window_high_threshold;
      `ADCC_WIN_INSIDE: window_hit = (next_sum > window_low_threshold)
        && (next_sum < window_high_threshold);
      `ADCC_WIN_OUTSIDE: window_hit = (next_sum < window_low_threshold)
        || (next_sum > window_high_threshold);
      default: window_hit = 1'b0;
    endcase
  end

  // start sources: software command or rising edge on the event input
  assign sw_start = wr_access && idx == `ADCC_IDX_COMMAND && pwdata[0];
  assign hw_start = start_event_input & event_sync & ~event_last;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ADCC_IDLE: begin
        if (enable && (sw_start || hw_start)) begin
          next_state = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE: begin
        if (!enable) begin
          next_state = ADCC_IDLE;
        end else if (sample_done && run_ok && last_sample) begin
          next_state = ADCC_FINISH;
        end
      end
      ADCC_FINISH: begin
        if (enable && free_running) begin
          next_state = ADCC_SAMPLE;
        end else begin
          next_state = ADCC_IDLE;
        end
      end
      default: next_state = ADCC_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ADCC_IDLE;
    end else if (ce) begin
      if (!enable) begin
        state <= ADCC_IDLE;
      end else begin
        state <= next_state;
      end
    end
  end

  // start bit: set on a start, cleared at completion or on disable
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_conversion <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        start_conversion <= 1'b0;
      end else begin
        start_conversion <= (next_state == ADCC_SAMPLE);
      end
    end
  end

  // accumulator and sample counter, cleared at every conversion start
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      accumulator <= `ADCC_RESET_WORD;
      sample_index <= 6'h00;
    end else if (ce) begin
      if (state != ADCC_SAMPLE || !enable) begin
        accumulator <= `ADCC_RESET_WORD;
        sample_index <= 6'h00;
      end else if (sample_done && run_ok) begin
        accumulator <= next_sum;
        sample_index <= sample_index + 6'h01;
      end
    end
  end

  // result register, written once per complete conversion
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      conversion_result <= `ADCC_RESET_WORD;
    end else if (ce) begin
      if (state == ADCC_SAMPLE && enable && sample_done && run_ok && last_sample) begin
        conversion_result <= next_sum;
      end
    end
  end

  // analog request is held through the conversion, dropped while halted
  assign sample_req = (state == ADCC_SAMPLE) & run_ok;

  // channel changes take effect only between conversions
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_channel <= 5'h00;
    end else if (ce) begin
      if (state != ADCC_SAMPLE) begin
        input_channel <= input_select;
      end
    end
  end

  assign reference_select = control_reference_prescale[5:4];
  assign sample_cap = control_reference_prescale[6];

  // converter clock prescaler, divide by 2 to 256
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prescale_count <= 8'h00;
      converter_clock_tick <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        prescale_count <= 8'h00;
        converter_clock_tick <= 1'b0;
      end else begin
        prescale_count <= prescale_count + 8'h01;
        converter_clock_tick <= (prescale_count
          | (8'hFF << ({1'b0, control_reference_prescale[2:0]} + 4'h1))) == 8'hFF;
      end
    end
  end

  // event input crosses from the event system, then edge detect
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      event_meta <= 1'b0;
      event_sync <= 1'b0;
      event_last <= 1'b0;
    end else if (ce) begin
      event_meta <= start_event;
      event_sync <= event_meta;
      event_last <= event_sync;
    end
  end

  // completion events, one cycle each
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result_ready_event <= 1'b0;
      window_match_event <= 1'b0;
    end else if (ce) begin
      result_ready_event <= 1'b0;
      window_match_event <= 1'b0;
      if (state == ADCC_SAMPLE && enable && sample_done && run_ok && last_sample) begin
        result_ready_event <= 1'b1;
        window_match_event <= window_hit;
      end
    end
  end

  // sticky flags: hardware set wins over a software clear
  assign flag_set = {window_match_event, result_ready_event};
  assign flag_clear = (wr_access && idx == `ADCC_IDX_INTERRUPT_CLEAR) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      interrupt_flags <= 2'h0;
    end else if (ce) begin
      interrupt_flags <= (interrupt_flags & ~flag_clear) | flag_set;
    end
  end

  // level interrupt until the flag is cleared or its enable bit is written to zero
  assign irq = |(interrupt_flags & interrupt_enable);

  // software-written registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      control_main <= `ADCC_RESET_BYTE;
      accumulation_count <= 3'h0;
      control_reference_prescale <= `ADCC_RESET_BYTE;
      control_delays <= `ADCC_RESET_BYTE;
      window_mode <= 3'h0;
      sample_length <= 5'h00;
      input_select <= 5'h00;
      start_event_input <= 1'b0;
      interrupt_enable <= 2'h0;
      run_in_debug <= 1'b0;
      byte_staging <= `ADCC_RESET_BYTE;
      window_low_threshold <= `ADCC_RESET_WORD;
      window_high_threshold <= `ADCC_RESET_WORD;
      duty_cycle_select <= 1'b0;
    end else if (wr_access) begin
      case (idx)
        `ADCC_IDX_CONTROL_MAIN:
          control_main <= pwdata[7:0] & `ADCC_MASK_CONTROL_MAIN;
        `ADCC_IDX_CONTROL_ACCUMULATION: accumulation_count <= pwdata[2:0];
        `ADCC_IDX_CONTROL_REFERENCE_PRESCALE:
          control_reference_prescale <= pwdata[7:0] & `ADCC_MASK_CONTROL_REFERENCE_PRESCALE;
        `ADCC_IDX_CONTROL_DELAYS: control_delays <= pwdata[7:0];
        `ADCC_IDX_CONTROL_WINDOW_MODE: window_mode <= pwdata[2:0];
        `ADCC_IDX_SAMPLE_LENGTH: sample_length <= pwdata[4:0];
        `ADCC_IDX_INPUT_SELECT: input_select <= pwdata[4:0];
        `ADCC_IDX_EVENT_CONTROL: start_event_input <= pwdata[0];
        `ADCC_IDX_INTERRUPT_ENABLE: interrupt_enable <= pwdata[1:0];
        `ADCC_IDX_DEBUG_CONTROL: run_in_debug <= pwdata[0];
        `ADCC_IDX_BYTE_STAGING: byte_staging <= pwdata[7:0];
        `ADCC_IDX_WINDOW_LOW_THRESHOLD: window_low_threshold <= pwdata[15:0];
        `ADCC_IDX_WINDOW_HIGH_THRESHOLD: window_high_threshold <= pwdata[15:0];
        `ADCC_IDX_CALIBRATION: duty_cycle_select <= pwdata[0];
        default: ;
      endcase
    end
  end

  // read decode; clear register reads zero
  always_comb begin
    read_value = 32'h00000000;
    mapped = 1'b1;
    case (idx)
      `ADCC_IDX_CONTROL_MAIN: read_value[7:0] = control_main;
      `ADCC_IDX_CONTROL_ACCUMULATION: read_value[2:0] = accumulation_count;
      `ADCC_IDX_CONTROL_REFERENCE_PRESCALE: read_value[7:0] = control_reference_prescale;
      `ADCC_IDX_CONTROL_DELAYS: read_value[7:0] = control_delays;
      `ADCC_IDX_CONTROL_WINDOW_MODE: read_value[2:0] = window_mode;
      `ADCC_IDX_SAMPLE_LENGTH: read_value[4:0] = sample_length;
      `ADCC_IDX_INPUT_SELECT: read_value[4:0] = input_select;
      `ADCC_IDX_COMMAND: read_value[0] = start_conversion;
      `ADCC_IDX_EVENT_CONTROL: read_value[0] = start_event_input;
      `ADCC_IDX_INTERRUPT_ENABLE: read_value[1:0] = interrupt_enable;
      `ADCC_IDX_INTERRUPT_FLAGS: read_value[1:0] = interrupt_flags;
      `ADCC_IDX_DEBUG_CONTROL: read_value[0] = run_in_debug;
      `ADCC_IDX_BYTE_STAGING: read_value[7:0] = byte_staging;
      `ADCC_IDX_INTERRUPT_CLEAR: read_value = 32'h00000000;
      `ADCC_IDX_CONVERSION_RESULT: read_value[15:0] = conversion_result;
      `ADCC_IDX_WINDOW_LOW_THRESHOLD: read_value[15:0] = window_low_threshold;
      `ADCC_IDX_WINDOW_HIGH_THRESHOLD: read_value[15:0] = window_high_threshold;
      `ADCC_IDX_CALIBRATION: read_value[0] = duty_cycle_select;
      default: mapped = 1'b0;
    endcase
  end

  // read data and error captured in the setup cycle, so no wait states
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup_phase) begin
        prdata <= (pwrite || paddr[1:0] != 2'h0) ? 32'h00000000 : read_value;
        pslverr <= ~mapped | (paddr[1:0] != 2'h0);
      end
    end
  end

endmodule : adcc_core

// File: hdl/adcc_regs.svh
// register indices, field positions and reset values of the converter control core
// assumes an apb bus with 32-bit data; byte address is four times the index
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// register indices
`define ADCC_IDX_CONTROL_MAIN 6'h00
`define ADCC_IDX_CONTROL_ACCUMULATION 6'h01
`define ADCC_IDX_CONTROL_REFERENCE_PRESCALE 6'h02
`define ADCC_IDX_CONTROL_DELAYS 6'h03
`define ADCC_IDX_CONTROL_WINDOW_MODE 6'h04
`define ADCC_IDX_SAMPLE_LENGTH 6'h05
`define ADCC_IDX_INPUT_SELECT 6'h06
`define ADCC_IDX_COMMAND 6'h08
`define ADCC_IDX_EVENT_CONTROL 6'h09
`define ADCC_IDX_INTERRUPT_ENABLE 6'h0A
`define ADCC_IDX_INTERRUPT_FLAGS 6'h0B
`define ADCC_IDX_DEBUG_CONTROL 6'h0C
`define ADCC_IDX_BYTE_STAGING 6'h0D
`define ADCC_IDX_INTERRUPT_CLEAR 6'h0E
`define ADCC_IDX_CONVERSION_RESULT 6'h10
`define ADCC_IDX_WINDOW_LOW_THRESHOLD 6'h12
`define ADCC_IDX_WINDOW_HIGH_THRESHOLD 6'h14
`define ADCC_IDX_CALIBRATION 6'h16

// control_main fields
`define ADCC_BIT_ENABLE 0
`define ADCC_BIT_FREE_RUNNING 1
`define ADCC_BIT_RESOLUTION_SELECT 2
`define ADCC_BIT_RUN_IN_STANDBY 7
// interrupt flag / enable / clear fields
`define ADCC_BIT_RESULT_READY 0
`define ADCC_BIT_WINDOW_MATCH 1

// writable masks, reserved bits read zero
`define ADCC_MASK_CONTROL_MAIN 8'h87
`define ADCC_MASK_CONTROL_REFERENCE_PRESCALE 8'h77
`define ADCC_MASK_SAMPLE_LENGTH 8'h1F

// reset values
`define ADCC_RESET_BYTE 8'h00
`define ADCC_RESET_WORD 16'h0000

// window modes
`define ADCC_WIN_NONE 3'h0
`define ADCC_WIN_BELOW 3'h1
`define ADCC_WIN_ABOVE 3'h2
`define ADCC_WIN_INSIDE 3'h3
`define ADCC_WIN_OUTSIDE 3'h4

`endif

// File: hdl/adcc_pkg.sv
// types shared by the converter control core
// assumes nothing beyond a systemverilog elaborator
package adcc_pkg;

  // conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_SAMPLE = 3'b010,
    ADCC_FINISH = 3'b100
  } adcc_state_type;

endpackage : adcc_pkg

// File: tb/adcc_core_chk.sv
// port-level assertions for the converter control core
// assumes one clock domain and byte addresses four apart
`timescale 1ns/1ps

module adcc_core_chk (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // system state and front end
  input wire logic standby_sleep,
  input wire logic debug_halt,
  input wire logic sample_req,
  input wire logic sample_done,
  // events and interrupt
  input wire logic result_ready_event,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic [7:0] ctl;
  assign wr = psel && penable && pwrite && ce;
  // shadow of control_main; enable and standby policy are not visible at the ports
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 8'h00;
    end else if (wr && paddr == 8'h00) begin
      ctl <= pwdata[7:0];
    end
  end
  property p_event_pulse;
    result_ready_event |=> !result_ready_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("result event longer than one cycle");
  property p_event_cause;
    result_ready_event |-> $past(sample_done && sample_req);
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("result event without a finishing sample");
  property p_irq_hold;
    $fell(irq) |-> $past(wr && (paddr == 8'h38 || paddr == 8'h28 || paddr == 8'h00));
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without a clear or mask write");
  property p_disabled;
    !ctl[0] |-> !sample_req;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("sampling while disabled");
  property p_standby;
    standby_sleep && !ctl[7] |-> !sample_req;
  endproperty
  a_standby: assert property (p_standby)
    else $error("sampling in standby without permission");
  property p_busy_bit;
    psel && !penable && !pwrite && ce && paddr == 8'h20 && sample_req |=> prdata[0];
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("start bit reads zero during a conversion");
  property p_free_run;
    result_ready_event && ctl[1:0] == 2'b11 |=> sample_req || standby_sleep || debug_halt;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free running did not restart");
  property p_misaligned;
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0;
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned access not refused");
  c_event: cover property (result_ready_event);
  c_irq: cover property ($rose(irq));
  c_refused: cover property (psel && penable && pslverr);
endmodule : adcc_core_chk

bind adcc_core adcc_core_chk i_adcc_core_chk (.clk, .rst_n, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pslverr, .standby_sleep, .debug_halt, .sample_req,
  .sample_done, .result_ready_event, .irq);

// File: tb/adcc_core_test.sv
// self-checking bench for the converter control core, apb tasks and a front-end stub
// assumes the front end answers each sample request after three cycles
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module adcc_core_test;
  logic clk, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, ex;
  logic pready, pslverr, er, sample_req, result_ready_event, irq, tick, wm_event;
  logic standby_sleep = 1'b0, debug_halt = 1'b0, start_event = 1'b0, sample_done = 1'b0;
  logic [9:0] sample_data = 10'h2D7;
  logic [7:0] regs [17] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24,
    8'h28, 8'h2C, 8'h30, 8'h34, 8'h40, 8'h48, 8'h50, 8'h58};
  int mismatches = 0, comparisons = 0, ev_count = 0, fe_cnt = 0, e0, n;
  int tk_count = 0, wm_count = 0;
  adcc_core i_adcc_core (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_sleep(standby_sleep), .debug_halt(debug_halt),
    .start_event(start_event), .sample_req(sample_req), .sample_done(sample_done),
    .sample_data(sample_data), .converter_clock_tick(tick), .input_channel(),
    .reference_select(), .sample_cap(), .result_ready_event(result_ready_event),
    .window_match_event(wm_event), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // front-end stub: one-cycle done pulse three cycles into each request; counts events
  always @(posedge clk) begin
    if (sample_req === 1'b1 && sample_done === 1'b0 && fe_cnt == 2) begin
      sample_done <= 1'b1;
      fe_cnt <= 0;
    end else begin
      sample_done <= 1'b0;
      fe_cnt <= (sample_req === 1'b1) ? fe_cnt + 1 : 0;
    end
    if (result_ready_event === 1'b1) ev_count <= ev_count + 1;
    if (tick === 1'b1) tk_count <= tk_count + 1;
    if (wm_event === 1'b1) wm_count <= wm_count + 1;
  end
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // bounded wait for k more result events
  task automatic wait_ev(input int k);
    int t;
    t = ev_count + k;
    for (int i = 0; i < 3000 && ev_count < t; i++) @(posedge clk);
    `CHK("event count", t, ev_count)
  endtask : wait_ev
  // irq compared after the edge's updates have landed
  task automatic chk_irq(input logic x);
    @(negedge clk);
    `CHK("irq", x, irq)
  endtask : chk_irq
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // watchdog sized well beyond the whole sequence
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, regs[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
      `CHK("pslverr", 1'b0, er)
    end
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped pslverr", 1'b1, er)
    apb(1'b0, 8'h01, 32'h0);
    `CHK("misaligned pslverr", 1'b1, er)
    $display("test registers done");
    // every accumulation code in both resolutions; reserved code acts as 64
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        n = (c == 7) ? 64 : (1 << c);
        ex = 32'(n) * (r ? 32'h0B5 : 32'h2D7);
        apb(1'b1, 8'h04, 32'(c));
        apb(1'b1, 8'h00, r ? 32'h5 : 32'h1);
        apb(1'b1, 8'h20, 32'h1);
        if (c > 1) begin
          apb(1'b0, 8'h20, 32'h0);
          `CHK("start bit busy", 32'h1, rd)
        end
        wait_ev(1);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("result", ex, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("start bit done", 32'h0, rd)
        apb(1'b0, 8'h2C, 32'h0);
        `CHK("flag set", 32'h1, rd)
        apb(1'b1, 8'h38, 32'h1);
        apb(1'b0, 8'h2C, 32'h0);
        `CHK("flag cleared", 32'h0, rd)
      end
    end
    $display("test accumulation done");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h28, 32'h1);
    apb(1'b1, 8'h20, 32'h1);
    wait_ev(1);
    repeat (20) @(posedge clk);
    chk_irq(1'b1);
    apb(1'b1, 8'h28, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, 8'h28, 32'h1);
    chk_irq(1'b1);
    apb(1'b1, 8'h38, 32'h1);
    chk_irq(1'b0);
    $display("test interrupt done");
    // free running waits for the command, then repeats until disabled
    apb(1'b1, 8'h00, 32'h3);
    e0 = ev_count;
    repeat (30) @(posedge clk);
    `CHK("no run before command", e0, ev_count)
    apb(1'b1, 8'h20, 32'h1);
    wait_ev(3);
    apb(1'b1, 8'h00, 32'h0);
    @(negedge clk);
    `CHK("abandoned request", 1'b0, sample_req)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("start bit abandoned", 32'h0, rd)
    e0 = ev_count;
    apb(1'b1, 8'h20, 32'h1);
    repeat (40) @(posedge clk);
    `CHK("idle while disabled", e0, ev_count)
    $display("test free running done");
    // standby pauses unless run_in_standby is set
    apb(1'b1, 8'h04, 32'h6);
    apb(1'b1, 8'h00, 32'h1);
    standby_sleep <= 1'b1;
    apb(1'b1, 8'h20, 32'h1);
    e0 = ev_count;
    repeat (300) @(posedge clk);
    `CHK("paused in standby", e0, ev_count)
    `CHK("no request in standby", 1'b0, sample_req)
    standby_sleep <= 1'b0;
    wait_ev(1);
    apb(1'b1, 8'h00, 32'h81);
    standby_sleep <= 1'b1;
    apb(1'b1, 8'h20, 32'h1);
    wait_ev(1);
    standby_sleep <= 1'b0;
    $display("test standby done");
    // event-started single conversions against the window compare
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b1, 8'h48, 32'h2D8);
    apb(1'b1, 8'h50, 32'h300);
    apb(1'b1, 8'h38, 32'h3);
    for (int w = 0; w < 2; w++) begin
      apb(1'b1, 8'h10, w ? 32'h3 : 32'h1);
      e0 = wm_count;
      start_event <= 1'b1;
      wait_ev(1);
      start_event <= 1'b0;
      apb(1'b0, 8'h2C, 32'h0);
      `CHK("window flags", w ? 32'h1 : 32'h3, rd)
      `CHK("window events", e0 + 1 - w, wm_count)
      apb(1'b1, 8'h38, 32'h3);
    end
    $display("test window done");
    // slowest converter clock: one tick per 256 cycles
    apb(1'b1, 8'h08, 32'h7);
    repeat (2) @(posedge clk);
    e0 = tk_count;
    repeat (512) @(posedge clk);
    `CHK("ticks per 512 cycles", e0 + 2, tk_count)
    $display("test prescaler done");
    complete_run();
  end
endmodule : adcc_core_test
